// ### design/bar_pkg.sv
/*
  package for the bus-loss reaction object bank: object indices, subindices,
  reset values, reaction codes, bus states and carrier structs.
  assumes a single mclk domain and an object-dictionary style access port.
*/
package bar_pkg;
  // ==========================================================
  // object indices and subindices
  localparam logic [15:0] IDX_LOADER_INFO   = 16'h4042;
  localparam logic [15:0] IDX_LOSS_REACTION = 16'h6007;
  localparam logic [15:0] IDX_LAST_ERROR    = 16'h603f;
  localparam logic [7:0]  SUB_COUNT         = 8'h00;
  localparam logic [7:0]  SUB_VERSION       = 8'h01;
  localparam logic [7:0]  SUB_FIELDBUS      = 8'h02;
  localparam logic [7:0]  SUB_HW_CLASS      = 8'h03;
  localparam logic [31:0] LOADER_ENTRIES    = 32'h0000_0003;
  // ==========================================================
  // reset values
  localparam logic [15:0] LOSS_REACTION_RST = 16'hffff;
  localparam logic [15:0] LAST_ERROR_RST    = 16'h0000;
  localparam logic [15:0] CTRL_WORD_RST     = 16'h0000;
  localparam logic [31:0] PROC_IN_RST       = 32'h0000_0000;
  localparam logic [31:0] NO_OBJECT_RSP     = 32'h0000_0000;
  // ==========================================================
  // reaction codes (signed 16-bit setting)
  localparam logic [15:0] REACT_CLEAR_INPUTS = 16'hffff;
  localparam logic [15:0] REACT_NONE         = 16'h0000;
  localparam logic [15:0] REACT_FAULT        = 16'h0001;
  localparam logic [15:0] REACT_DISABLE_V    = 16'h0002;
  localparam logic [15:0] REACT_QUICK_STOP   = 16'h0003;

  typedef enum logic [1:0] {
    BAR_BUS_INIT,
    BAR_BUS_PREOP,
    BAR_BUS_SAFEOP,
    BAR_BUS_OP
  } bar_bus_state_t;

  // object access request from the fieldbus slave core
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } bar_obj_req_t;

  // object access answer
  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] rdata;
  } bar_obj_rsp_t;

  // one-cycle requests toward the drive state machine
  typedef struct packed {
    logic fault_action;
    logic quick_stop;
    logic disable_voltage;
  } bar_drive_req_t;
endpackage

// ### design/bar_loss_react.sv
/*
  decodes the bus-loss reaction setting on a bus error into drive requests.
  assumes bus_err is a one-cycle event from the bus watchdog logic.
*/
`timescale 1ns/1ps
module bar_loss_react (
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  wire logic                    bus_err,
  input  wire logic [15:0]             reaction,
  output bar_pkg::bar_drive_req_t      drive_req_q,
  output logic                         clear_inputs_q
);
  // ==========================================================
  // reaction decode, at most one registered pulse per bus error
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      drive_req_q    <= '0;
      clear_inputs_q <= 1'b0;
    end else begin
      clear_inputs_q              <= bus_err && (reaction == bar_pkg::REACT_CLEAR_INPUTS);
      drive_req_q.disable_voltage <= bus_err && (reaction == bar_pkg::REACT_DISABLE_V);
      drive_req_q.fault_action    <= bus_err && (reaction == bar_pkg::REACT_FAULT);
      drive_req_q.quick_stop      <= bus_err && (reaction == bar_pkg::REACT_QUICK_STOP);
    end
  end
endmodule

// ### design/bar_objects.sv
/*
  bus-loss reaction object bank: loader information, reaction setting,
  last error code, bus state fallback and process-input clearing.
  assumes requests come from a fieldbus slave core in the mclk domain,
  at most one per cycle, and bus_err is a one-cycle pulse.
*/
`timescale 1ns/1ps
module bar_objects #(
  parameter logic [15:0] LOADER_MAJOR = 16'h0001, // arbitrary
  parameter logic [15:0] LOADER_MINOR = 16'h0000, // arbitrary
  parameter logic [31:0] LOADER_BUSES = 32'h0000_0001, // arbitrary
  parameter logic [31:0] LOADER_CLASS = 32'h0000_0000  // arbitrary
) (
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  bar_pkg::bar_obj_req_t        req,
  output bar_pkg::bar_obj_rsp_t        rsp_q,
  input  wire logic                    restore_vld,
  input  wire logic [15:0]             restore_val,
  input  wire logic                    bus_go_op,
  input  wire logic                    bus_go_preop,
  input  wire logic                    bus_err,
  input  wire logic                    hist_push,
  input  wire logic [31:0]             hist_entry,
  input  wire logic                    pin_wr,
  input  wire logic [31:0]             pin_val,
  input  wire logic                    ctrl_wr,
  input  wire logic [15:0]             ctrl_val,
  output logic [31:0]                  proc_in_q,
  output logic [15:0]                  ctrl_word_q,
  output bar_pkg::bar_bus_state_t      bus_state_q,
  output bar_pkg::bar_drive_req_t      drive_req_q,
  output logic [15:0]                  reaction_q,
  output logic [15:0]                  last_error_q
);
  logic clear_inputs_q;

  function automatic logic hit(input bar_pkg::bar_obj_req_t r, input logic [15:0] idx);
    hit = r.index == idx;
  endfunction

  // ==========================================================
  // reaction decode
  bar_loss_react u_react (
    .mclk           (mclk),
    .arst_n         (arst_n),
    .bus_err        (bus_err),
    .reaction       (reaction_q),
    .drive_req_q    (drive_req_q),
    .clear_inputs_q (clear_inputs_q)
  );

  // ==========================================================
  // reaction setting; a restore beats a master write in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reaction_q <= bar_pkg::LOSS_REACTION_RST;
    end else if (restore_vld) begin
      reaction_q <= restore_val;
    end else if (req.wr && hit(req, bar_pkg::IDX_LOSS_REACTION)) begin
      reaction_q <= req.wdata[15:0];
    end
  end

  // ==========================================================
  // last error follows the newest history entry
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      last_error_q <= bar_pkg::LAST_ERROR_RST;
    end else if (hist_push) begin
      last_error_q <= hist_entry[15:0];
    end
  end

  // ==========================================================
  // bus state; error fallback wins over a request to go operational
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state_q <= bar_pkg::BAR_BUS_INIT;
    end else begin
      case (bus_state_q)
        bar_pkg::BAR_BUS_OP: begin
          if (bus_err) begin
            bus_state_q <= bar_pkg::BAR_BUS_SAFEOP;
          end
        end
        bar_pkg::BAR_BUS_INIT: begin
          if (bus_go_preop) begin
            bus_state_q <= bar_pkg::BAR_BUS_PREOP;
          end
        end
        bar_pkg::BAR_BUS_PREOP,
        bar_pkg::BAR_BUS_SAFEOP: begin
          if (bus_go_op && !bus_err) begin
            bus_state_q <= bar_pkg::BAR_BUS_OP;
          end
        end
        default: begin
          bus_state_q <= bar_pkg::BAR_BUS_INIT;
        end
      endcase
    end
  end

  // ==========================================================
  // process inputs and control word; the clear wins over a late write,
  // so no stale master value survives a bus loss with the reaction set to REACT_CLEAR_INPUTS
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      proc_in_q <= bar_pkg::PROC_IN_RST;
    end else if (clear_inputs_q) begin
      proc_in_q <= bar_pkg::PROC_IN_RST;
    end else if (pin_wr) begin
      proc_in_q <= pin_val;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_word_q <= bar_pkg::CTRL_WORD_RST;
    end else if (clear_inputs_q) begin
      ctrl_word_q <= bar_pkg::CTRL_WORD_RST;
    end else if (ctrl_wr) begin
      ctrl_word_q <= ctrl_val;
    end
  end

  // ==========================================================
  // object read port, answer one cycle after the request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_q <= '0;
    end else begin
      rsp_q.ack   <= req.rd || req.wr;
      rsp_q.abort <= 1'b0;
      rsp_q.rdata <= bar_pkg::NO_OBJECT_RSP;
      if (req.rd && hit(req, bar_pkg::IDX_LOADER_INFO)) begin
        case (req.sub)
          bar_pkg::SUB_COUNT:    rsp_q.rdata <= bar_pkg::LOADER_ENTRIES;
          bar_pkg::SUB_VERSION:  rsp_q.rdata <= {LOADER_MAJOR, LOADER_MINOR};
          bar_pkg::SUB_FIELDBUS: rsp_q.rdata <= LOADER_BUSES;
          bar_pkg::SUB_HW_CLASS: rsp_q.rdata <= LOADER_CLASS;
          default:               rsp_q.abort <= 1'b1;
        endcase
      end else if (req.rd && hit(req, bar_pkg::IDX_LOSS_REACTION)) begin
        rsp_q.rdata <= {16'h0000, reaction_q};
      end else if (req.rd && hit(req, bar_pkg::IDX_LAST_ERROR)) begin
        rsp_q.rdata <= {16'h0000, last_error_q};
      end else if (req.rd) begin
        rsp_q.abort <= 1'b1;
      end else if (req.wr && !hit(req, bar_pkg::IDX_LOSS_REACTION)) begin
        rsp_q.abort <= 1'b1; // read-only or unknown object
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_err_at(logic [15:0] code);
    bus_err && reaction_q == code && !restore_vld;
  endsequence

  // a read of one loader subindex, taken on this edge
  sequence s_loader_rd(logic [7:0] s);
    req.rd && hit(req, bar_pkg::IDX_LOADER_INFO) && req.sub == s;
  endsequence

  a_bus_fallback: assert property (@(posedge mclk) disable iff (!arst_n)
    bus_state_q == bar_pkg::BAR_BUS_OP && bus_err |=> bus_state_q == bar_pkg::BAR_BUS_SAFEOP)
    else $error("bus error did not leave operational");
  a_inputs_cleared: assert property (@(posedge mclk) disable iff (!arst_n)
    s_err_at(bar_pkg::REACT_CLEAR_INPUTS) |=> ##1 proc_in_q == 32'h0000_0000)
    else $error("process inputs not cleared");
  a_ctrl_cleared: assert property (@(posedge mclk) disable iff (!arst_n)
    s_err_at(bar_pkg::REACT_CLEAR_INPUTS) |=> ##1 ctrl_word_q == 16'h0000)
    else $error("control word not cleared");
  a_disable_volt: assert property (@(posedge mclk) disable iff (!arst_n)
    drive_req_q.disable_voltage |-> $past(bus_err) && $past(reaction_q) == 16'h0002)
    else $error("disable voltage without cause");
  a_none_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    s_err_at(bar_pkg::REACT_NONE) |=> drive_req_q == 3'b000 && !clear_inputs_q)
    else $error("reaction zero acted");
  a_fault_qstop: assert property (@(posedge mclk) disable iff (!arst_n)
    bus_err && reaction_q inside {16'h0001, 16'h0003} |=>
      drive_req_q.fault_action == ($past(reaction_q) == 16'h0001) &&
      drive_req_q.quick_stop == ($past(reaction_q) == 16'h0003))
    else $error("fault or quick stop request wrong");
  a_error_track: assert property (@(posedge mclk) disable iff (!arst_n)
    hist_push |=> last_error_q == $past(hist_entry[15:0]))
    else $error("error code not newest history entry");
  a_error_read: assert property (@(posedge mclk) disable iff (!arst_n)
    req.rd && hit(req, 16'h603f) && !hist_push |=> rsp_q.rdata == {16'h0000, last_error_q})
    else $error("error code read wrong");
  a_loader_count: assert property (@(posedge mclk) disable iff (!arst_n)
    req.rd && hit(req, 16'h4042) && req.sub == 8'h00 |=> rsp_q.rdata == 32'h0000_0003 && rsp_q.ack)
    else $error("loader count not three");
  a_reaction_rst: assert property (@(posedge mclk)
    !arst_n |-> reaction_q == 16'hffff)
    else $error("reaction reset value wrong");
  a_loader_version: assert property (@(posedge mclk) disable iff (!arst_n)
    s_loader_rd(bar_pkg::SUB_VERSION) |=> rsp_q.rdata[31:16] == LOADER_MAJOR && rsp_q.rdata[15:0] == LOADER_MINOR)
    else $error("loader version word wrong");
  a_loader_buses: assert property (@(posedge mclk) disable iff (!arst_n)
    s_loader_rd(bar_pkg::SUB_FIELDBUS) |=> rsp_q.rdata == LOADER_BUSES && !rsp_q.abort)
    else $error("loader fieldbus word wrong");
  a_clear_cause: assert property (@(posedge mclk) disable iff (!arst_n)
    clear_inputs_q |-> $past(bus_err) && $past(reaction_q) == 16'hffff)
    else $error("input clear without cause");
  a_drive_single: assert property (@(posedge mclk) disable iff (!arst_n)
    $onehot0({drive_req_q.fault_action, drive_req_q.quick_stop, drive_req_q.disable_voltage}))
    else $error("more than one drive request");
  a_error_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    !hist_push |=> $stable(last_error_q))
    else $error("error code changed without history entry");
endmodule

// ### verification/bar_master_model.sv
/*
  fieldbus master model: issues object reads and writes to the bank.
  assumes the bank takes a request on one edge and answers the cycle after.
*/
`timescale 1ns/1ps
module bar_master_model (
  input  wire logic             mclk,
  output bar_pkg::bar_obj_req_t req,
  input  bar_pkg::bar_obj_rsp_t rsp_q
);
  // ==========================================
  // object access
  // idle request at time zero so nothing is taken before the first call
  initial req = '0;

  // held across exactly one take edge; answer read 1 ns after that same edge
  task automatic access(input logic w, input logic [15:0] x, input logic [7:0] s,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic ab, output logic ak);
    @(posedge mclk);
    #1;
    req = '{rd: !w, wr: w, index: x, sub: s, wdata: d};
    @(posedge mclk);
    #1;
    req = '{rd: 1'b0, wr: 1'b0, index: x, sub: s, wdata: d};
    rd = rsp_q.rdata;
    ab = rsp_q.abort;
    ak = rsp_q.ack;
  endtask
endmodule

// ### verification/bar_objects_tb.sv
/*
  self-checking bench for the bus-loss reaction object bank.
  assumes bar_master_model drives the object port; 20 MHz mclk.
*/
`timescale 1ns/1ps
module bar_objects_tb;
  localparam logic [15:0] MAJ = 16'h0004;
  localparam logic [15:0] MIN = 16'h0002;
  localparam logic [31:0] BUS = 32'h0000_0003; // arbitrary
  localparam logic [31:0] CLS = 32'h0000_0005; // arbitrary
  logic                    mclk, arst_n, restore_vld, bus_go_op, bus_go_preop;
  logic                    bus_err, hist_push, pin_wr, ctrl_wr;
  logic [15:0]             restore_val, ctrl_val, ctrl_word_q, reaction_q, last_error_q;
  logic [31:0]             hist_entry, pin_val, proc_in_q, rnd;
  bar_pkg::bar_obj_req_t   req;
  bar_pkg::bar_obj_rsp_t   rsp_q;
  bar_pkg::bar_bus_state_t bus_state_q;
  bar_pkg::bar_drive_req_t drive_req_q;
  int                      num_errors, checked, cyc;
  logic [15:0]             codes [5];
  logic [31:0]             li [4];

  bar_master_model i_bar_master_model (.mclk(mclk), .req(req), .rsp_q(rsp_q));
  bar_objects #(.LOADER_MAJOR(MAJ), .LOADER_MINOR(MIN), .LOADER_BUSES(BUS), .LOADER_CLASS(CLS))
  i_bar_objects (.mclk(mclk), .arst_n(arst_n), .req(req), .rsp_q(rsp_q), .restore_vld(restore_vld),
    .restore_val(restore_val), .bus_go_op(bus_go_op), .bus_go_preop(bus_go_preop), .bus_err(bus_err),
    .hist_push(hist_push), .hist_entry(hist_entry), .pin_wr(pin_wr), .pin_val(pin_val),
    .ctrl_wr(ctrl_wr), .ctrl_val(ctrl_val), .proc_in_q(proc_in_q), .ctrl_word_q(ctrl_word_q),
    .bus_state_q(bus_state_q), .drive_req_q(drive_req_q), .reaction_q(reaction_q),
    .last_error_q(last_error_q));

  // ==========================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // fault, quick stop, disable voltage in port order
  function automatic logic [2:0] exp_drv(input logic [15:0] c);
    exp_drv = {c == bar_pkg::REACT_FAULT, c == bar_pkg::REACT_QUICK_STOP, c == bar_pkg::REACT_DISABLE_V};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // one object access; rdata only judged on reads
  task automatic xfer(input logic w, input logic [15:0] x, input logic [7:0] s,
                      input logic [31:0] d, input logic [31:0] e, input logic a);
    logic [31:0] rd;
    logic        ab, ak;
    i_bar_master_model.access(w, x, s, d, rd, ab, ak);
    chk("ack", 32'h1, {31'h0, ak});
    chk("abort", {31'h0, a}, {31'h0, ab});
    if (!w) chk("rdata", e, rd);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    {arst_n, restore_vld, bus_go_op, bus_go_preop, bus_err, hist_push, pin_wr, ctrl_wr} = 8'h80;
    {restore_val, ctrl_val, hist_entry, pin_val} = '0;
    rnd = 32'h500c;
    codes = '{bar_pkg::REACT_CLEAR_INPUTS, bar_pkg::REACT_NONE, bar_pkg::REACT_FAULT,
              bar_pkg::REACT_DISABLE_V, bar_pkg::REACT_QUICK_STOP};
    li = '{bar_pkg::LOADER_ENTRIES, {MAJ, MIN}, BUS, CLS};
    // a real falling edge, so reset does not hinge on time-zero ordering
    #1;
    arst_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    chk("reaction_rst", 32'h0000_ffff, {16'h0, reaction_q});
    xfer(1'b0, bar_pkg::IDX_LOSS_REACTION, 8'h00, 32'h0, 32'h0000_ffff, 1'b0);
    xfer(1'b0, bar_pkg::IDX_LAST_ERROR, 8'h00, 32'h0, 32'h0, 1'b0);
    // loader array, subindex 4 is past the end and must abort
    for (int s = 0; s < 5; s++) begin
      xfer(1'b0, bar_pkg::IDX_LOADER_INFO, 8'(s), 32'h0, s < 4 ? li[s] : 32'h0, s == 4);
    end
    xfer(1'b1, bar_pkg::IDX_LOADER_INFO, 8'h01, rnd, 32'h0, 1'b1);
    xfer(1'b1, bar_pkg::IDX_LAST_ERROR, 8'h00, rnd, 32'h0, 1'b1);
    $display("test identity done");
    // newest history entry lands in the error register
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      @(posedge mclk);
      #1;
      hist_push = 1'b1;
      hist_entry = rnd;
      @(posedge mclk);
      #1;
      hist_push = 1'b0;
      chk("last_error", {16'h0, rnd[15:0]}, {16'h0, last_error_q});
      xfer(1'b0, bar_pkg::IDX_LAST_ERROR, 8'h00, 32'h0, {16'h0, rnd[15:0]}, 1'b0);
    end
    $display("test history done");
    // every reaction code against a live bus error
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      xfer(1'b1, bar_pkg::IDX_LOSS_REACTION, 8'h00, {rnd[31:16], codes[i]}, 32'h0, 1'b0);
      @(posedge mclk);
      #1;
      {pin_wr, ctrl_wr, bus_go_preop} = 3'b111;
      pin_val = rnd;
      ctrl_val = rnd[15:0];
      @(posedge mclk);
      #1;
      {pin_wr, ctrl_wr, bus_go_preop, bus_go_op} = 4'b0001;
      // wait past each edge so the state is read settled, not in the edge's own time step
      for (int k = 0; k < 8 && bus_state_q !== bar_pkg::BAR_BUS_OP; k++) begin
        @(posedge mclk);
        #1;
      end
      chk("bus_op", 32'(bar_pkg::BAR_BUS_OP), 32'(bus_state_q));
      bus_go_op = 1'b0;
      bus_err = 1'b1;
      @(posedge mclk);
      #1;
      bus_err = 1'b0;
      chk("bus_safeop", 32'(bar_pkg::BAR_BUS_SAFEOP), 32'(bus_state_q));
      chk("drive_req", {29'h0, exp_drv(codes[i])}, {29'h0, drive_req_q});
      @(posedge mclk);
      #1;
      chk("drive_idle", 32'h0, {29'h0, drive_req_q});
      chk("proc_in", i == 0 ? 32'h0 : rnd, proc_in_q);
      chk("ctrl_word", i == 0 ? 32'h0 : {16'h0, rnd[15:0]}, {16'h0, ctrl_word_q});
    end
    // a go-operational request in the cycle of a bus error must be ignored
    @(posedge mclk);
    #1;
    {bus_go_op, bus_err} = 2'b11;
    @(posedge mclk);
    #1;
    {bus_go_op, bus_err} = 2'b00;
    chk("bus_refused", 32'(bar_pkg::BAR_BUS_SAFEOP), 32'(bus_state_q));
    $display("test reactions done");
    // restore of a saved setting
    @(posedge mclk);
    #1;
    restore_vld = 1'b1;
    restore_val = rnd[31:16];
    @(posedge mclk);
    #1;
    restore_vld = 1'b0;
    xfer(1'b0, bar_pkg::IDX_LOSS_REACTION, 8'h00, 32'h0, {16'h0, rnd[31:16]}, 1'b0);
    $display("test restore done");
    report_and_stop();
  end
endmodule
